//--- rtl/hold_arb_cfg.svh
// Offsets, field positions, reset values and timing counts for the hold arbiter
`ifndef HOLD_ARB_CFG_SVH
`define HOLD_ARB_CFG_SVH
`define IDX_PORT          16'h0022
`define DATA_PORT         16'h0024
`define IDX_CONTROL_ONE   8'h20
`define IDX_SHADOW_ONE    8'h22
`define CTL_WR_MASK       8'h3A
`define CTL_RESET         8'h02
`define CTL_TURBO_BIT     4
`define CTL_VERSION       2'h0
`define SHD_WR_MASK       8'hFC
`define SHD_RESET         8'hE4
`define SHD_HIDDEN_BIT    2
`define CLK_PERIOD_PS     4000
`define CLK_MHZ           250
`define SLOW_MODE_TIMEBASE_MHZ         12
`define SLOW_DIV_CYCLES   (`CLK_MHZ / `SLOW_MODE_TIMEBASE_MHZ)
`define SLOW_PERIOD_TICKS 3
`define REFRESH_PERIOD_NS 15000
`define REFRESH_CYCLES    ((`REFRESH_PERIOD_NS * 1000) / `CLK_PERIOD_PS)
`define REFRESH_LEN       8
`endif

//--- rtl/hold_arb_pkg.sv
// Types shared by the hold arbiter
package hold_arb_pkg;
  typedef enum logic [1:0] {ARB_IDLE, ARB_WAIT_ACK, ARB_REFRESH, ARB_GRANT} arb_state_t;
  typedef enum logic [1:0] {CYC_NONE, CYC_DMA8, CYC_DMA16, CYC_MASTER} cycle_kind_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } io_req_t;
endpackage : hold_arb_pkg

//--- rtl/cpu_hold_bus_arbiter.sv
// Bus ownership arbiter: CPU hold, refresh, DMA/master grant, slow mode, indexed config
// Behaviour
// RQ1 - Arbitrate bus among CPU, DMA, bus masters and refresh.
// RQ2 - Raise CPU hold for DMA, master or conventional refresh.
// RQ3 - CPU finishes its cycle, then acknowledges hold and floats.
// RQ4 - After acknowledge, run refresh or grant DMA/master per winner.
// RQ5 - Hidden refresh runs with CPU hold kept low.
// RQ6 - Refresh versus DMA/master served first-come first-served.
// RQ7 - Refresh arriving during a grant is latched, served right after.
// RQ8 - A requester behind refresh keeps requesting; dropped requests are forgotten.
// RQ9 - One shared request; address enables tell 8/16-bit DMA or master.
// RQ10 - Slow mode drives hold periodically from a 12 MHz-class timebase.
// RQ11 - Slow mode holds CPU two thirds of each period, frees one third.
// RQ12 - Turbo control enable is bit 4 of register 20h, 386-class only.
// RQ13 - With turbo control on, low turbo pin applies two-thirds throttling.
// RQ14 - Software writes index to port 22h, then accesses port 24h.
// RQ15 - Index invalidated after every data access.
// RQ16 - Reserved bits reset to zero, written as zero.
// RQ17 - Bits 7-6 of register 20h are a read-only version field.
// RQ18 - Index 22h bit 2 low enables hidden refresh; resets high.
// RQ19 - Internal timer requests refresh about every 15 microseconds.
// RQ20 - Hold drops when the served requester ends and nothing waits.
`timescale 1ns/1ps
`default_nettype none
`include "hold_arb_cfg.svh"
module cpu_hold_bus_arbiter (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire hold_arb_pkg::io_req_t      io_req_i,
  output logic [7:0]                      io_rdata_o,
  input  wire logic                       cpu_hlda_i,
  input  wire logic                       dma_master_request_i,
  input  wire logic                       byte_dma_addr_enable_n_i,
  input  wire logic                       word_dma_addr_enable_n_i,
  input  wire logic                       local_request_turbo_in_n_i,
  input  wire logic                       cpu_mode_legacy_i,
  input  wire logic                       master_refresh_req_i,
  output logic                            cpu_hold_o,
  output logic                            refresh_cycle_n_o,
  output logic                            dma_master_grant_o,
  output hold_arb_pkg::cycle_kind_t       cycle_kind_o
);

  // Two-stage synchronisers for every pin; stage one feeds only stage two
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // Idle pin levels, so no false request or refresh edge follows reset
      pin_meta <= 7'h70;
      pin_sync <= 7'h70;
    end else begin
      pin_meta <= {local_request_turbo_in_n_i, byte_dma_addr_enable_n_i, word_dma_addr_enable_n_i,
                   cpu_mode_legacy_i, master_refresh_req_i, dma_master_request_i, cpu_hlda_i};
      pin_sync <= pin_meta;
    end
  end
  logic hlda_s, hrq_s, ext_rfsh_s, legacy_s, word_dma_addr_enable_n_n_s, byte_dma_addr_enable_n_n_s, turbo_n_s;
  assign {turbo_n_s, byte_dma_addr_enable_n_n_s, word_dma_addr_enable_n_n_s, legacy_s, ext_rfsh_s, hrq_s, hlda_s} = pin_sync;

  // Configuration registers and index
  logic [7:0] control_one;
  logic [7:0] shadow_one;
  logic [7:0] idx;
  logic       idx_valid;
  logic       data_acc;
  assign data_acc = (io_req_i.wr || io_req_i.rd) && io_req_i.addr == `DATA_PORT;

  // Index port; any data port access voids it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx       <= 8'h00;
      idx_valid <= 1'b0;
    end else if (io_req_i.wr && io_req_i.addr == `IDX_PORT) begin
      idx       <= io_req_i.wdata;                          // [RQ14]
      idx_valid <= 1'b1;
    end else if (data_acc) begin
      idx_valid <= 1'b0;                                    // [RQ15]
    end
  end

  // Register writes; masks keep reserved and version bits fixed
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      control_one <= `CTL_RESET;                            // [RQ16]
      shadow_one  <= `SHD_RESET;                            // [RQ18]
    end else if (io_req_i.wr && data_acc && idx_valid) begin
      if (idx == `IDX_CONTROL_ONE) begin
        control_one <= io_req_i.wdata & `CTL_WR_MASK;       // [RQ16] [RQ17]
      end else if (idx == `IDX_SHADOW_ONE) begin
        shadow_one <= io_req_i.wdata & `SHD_WR_MASK;        // [RQ16]
      end
    end
  end

  // Read data; unindexed or unknown index reads as zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_req_i.rd && data_acc) begin
      if (idx_valid && idx == `IDX_CONTROL_ONE) begin
        io_rdata_o <= {`CTL_VERSION, control_one[5:0]};     // [RQ17]
      end else if (idx_valid && idx == `IDX_SHADOW_ONE) begin
        io_rdata_o <= shadow_one;
      end else begin
        io_rdata_o <= 8'h00;
      end
    end
  end

  logic hidden_en;
  assign hidden_en = !shadow_one[`SHD_HIDDEN_BIT];          // [RQ18]

  // Refresh rate generator
  logic [11:0] rfsh_cnt;
  logic        rfsh_tick;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rfsh_cnt  <= 12'h000;
      rfsh_tick <= 1'b0;
    end else begin
      rfsh_tick <= (rfsh_cnt == 12'(`REFRESH_CYCLES - 1));  // [RQ19]
      rfsh_cnt  <= (rfsh_cnt == 12'(`REFRESH_CYCLES - 1)) ? 12'h000 : rfsh_cnt + 12'h001;
    end
  end

  // Slow-mode timebase and two-thirds hold waveform
  logic [4:0] div_cnt;
  logic [1:0] phase;
  logic       slow_mode;
  logic       slow_hold;
  assign slow_mode = legacy_s && control_one[`CTL_TURBO_BIT] && !turbo_n_s;  // [RQ12] [RQ13]
  assign slow_hold = slow_mode && phase != 2'(`SLOW_PERIOD_TICKS - 1);        // [RQ11]
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt <= 5'h00;
      phase   <= 2'h0;
    end else if (div_cnt == 5'(`SLOW_DIV_CYCLES - 1)) begin
      div_cnt <= 5'h00;                                     // [RQ10]
      phase   <= (phase == 2'(`SLOW_PERIOD_TICKS - 1)) ? 2'h0 : phase + 2'h1;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  // Arbiter state
  hold_arb_pkg::arb_state_t state;
  hold_arb_pkg::arb_state_t next_state;
  logic       rfsh_pend;
  logic       rfsh_first;
  logic       rfsh_hidden;
  logic [2:0] rfsh_len;
  logic       rfsh_done;
  logic       rfsh_serve;
  logic       rfsh_win;
  assign rfsh_done  = state == hold_arb_pkg::ARB_REFRESH && rfsh_len == 3'(`REFRESH_LEN - 1);
  assign rfsh_serve = next_state == hold_arb_pkg::ARB_REFRESH && state != hold_arb_pkg::ARB_REFRESH;
  assign rfsh_win   = rfsh_pend && (rfsh_first || !hrq_s);  // [RQ6]

  // Pending refresh latch; a new request wins over the serve clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rfsh_pend  <= 1'b0;
      rfsh_first <= 1'b0;
    end else if (rfsh_tick || ext_rfsh_s) begin
      rfsh_pend  <= 1'b1;                                   // [RQ7]
      rfsh_first <= (rfsh_pend && !rfsh_serve) ? rfsh_first : !hrq_s;  // [RQ6]
    end else if (rfsh_serve) begin
      rfsh_pend  <= 1'b0;
      rfsh_first <= 1'b0;
    end
  end

  // Ownership sequencer
  always_comb begin
    next_state = state;
    case (state)
      hold_arb_pkg::ARB_IDLE: begin
        if (rfsh_pend && hidden_en && !hrq_s) begin
          next_state = hold_arb_pkg::ARB_REFRESH;           // [RQ5]
        // An acknowledge left over from the last hold must clear first, or it grants early
        end else if ((hrq_s || rfsh_pend) && !(hlda_s && !cpu_hold_o)) begin
          next_state = hold_arb_pkg::ARB_WAIT_ACK;          // [RQ1] [RQ2]
        end
      end
      hold_arb_pkg::ARB_WAIT_ACK: begin
        if (hlda_s) begin                                   // [RQ3]
          if (rfsh_win) begin
            next_state = hold_arb_pkg::ARB_REFRESH;         // [RQ4] [RQ6]
          end else if (hrq_s) begin
            next_state = hold_arb_pkg::ARB_GRANT;           // [RQ4]
          end else begin
            next_state = hold_arb_pkg::ARB_IDLE;            // [RQ8] [RQ20]
          end
        end
      end
      hold_arb_pkg::ARB_GRANT: begin
        if (!hrq_s) begin
          next_state = rfsh_pend ? hold_arb_pkg::ARB_REFRESH : hold_arb_pkg::ARB_IDLE;  // [RQ7] [RQ20]
        end
      end
      hold_arb_pkg::ARB_REFRESH: begin
        if (rfsh_done) begin
          if (hrq_s && !rfsh_hidden && hlda_s) begin
            next_state = hold_arb_pkg::ARB_GRANT;           // [RQ6]
          end else begin
            next_state = hold_arb_pkg::ARB_IDLE;            // [RQ20]
          end
        end
      end
      default: next_state = hold_arb_pkg::ARB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= hold_arb_pkg::ARB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Refresh cycle length and whether it runs hidden
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rfsh_len    <= 3'h0;
      rfsh_hidden <= 1'b0;
    end else if (rfsh_serve) begin
      rfsh_len    <= 3'h0;
      rfsh_hidden <= state == hold_arb_pkg::ARB_IDLE;       // [RQ5]
    end else if (state == hold_arb_pkg::ARB_REFRESH) begin
      rfsh_len <= rfsh_len + 3'h1;
    end
  end

  // Registered outputs; hidden refresh leaves hold to the slow waveform only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_hold_o         <= 1'b0;
      refresh_cycle_n_o  <= 1'b1;
      dma_master_grant_o <= 1'b0;
    end else begin
      cpu_hold_o <= slow_hold || next_state == hold_arb_pkg::ARB_WAIT_ACK ||
                    next_state == hold_arb_pkg::ARB_GRANT ||
                    (next_state == hold_arb_pkg::ARB_REFRESH &&
                     !(rfsh_serve ? state == hold_arb_pkg::ARB_IDLE : rfsh_hidden));  // [RQ2] [RQ5] [RQ10]
      refresh_cycle_n_o  <= next_state != hold_arb_pkg::ARB_REFRESH;  // [RQ4]
      dma_master_grant_o <= next_state == hold_arb_pkg::ARB_GRANT;    // [RQ4]
    end
  end

  // Cycle type during a grant from the address enables
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cycle_kind_o <= hold_arb_pkg::CYC_NONE;
    end else if (state != hold_arb_pkg::ARB_GRANT) begin
      cycle_kind_o <= hold_arb_pkg::CYC_NONE;
    end else if (!byte_dma_addr_enable_n_n_s) begin
      cycle_kind_o <= hold_arb_pkg::CYC_DMA8;               // [RQ9]
    end else if (!word_dma_addr_enable_n_n_s) begin
      cycle_kind_o <= hold_arb_pkg::CYC_DMA16;              // [RQ9]
    end else begin
      cycle_kind_o <= hold_arb_pkg::CYC_MASTER;             // [RQ9]
    end
  end

  hold_on_grant_a: assert property (@(posedge clk_i) disable iff (!rstn_i)  // [RQ2]
    dma_master_grant_o |-> cpu_hold_o) else $error("grant without cpu hold");
  grant_after_ack_a: assert property (@(posedge clk_i) disable iff (!rstn_i)  // [RQ4]
    $rose(dma_master_grant_o) |-> $past(hlda_s)) else $error("grant before hold acknowledge");
  hidden_no_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)  // [RQ5]
    (state == hold_arb_pkg::ARB_REFRESH && rfsh_hidden && !rfsh_done && !slow_hold) |=> !cpu_hold_o)
    else $error("hold raised during hidden refresh");
  fifo_refresh_a: assert property (@(posedge clk_i) disable iff (!rstn_i)  // [RQ6]
    (state == hold_arb_pkg::ARB_WAIT_ACK && hlda_s && rfsh_pend && rfsh_first)
    |=> state == hold_arb_pkg::ARB_REFRESH ##1 !refresh_cycle_n_o) else $error("earlier refresh not first");
  refresh_after_grant_a: assert property (@(posedge clk_i) disable iff (!rstn_i)  // [RQ7]
    (state == hold_arb_pkg::ARB_GRANT && !hrq_s && rfsh_pend) |=> state == hold_arb_pkg::ARB_REFRESH)
    else $error("queued refresh not served after grant");
  release_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)  // [RQ20]
    (state == hold_arb_pkg::ARB_GRANT && !hrq_s && !rfsh_pend && !rfsh_tick && !ext_rfsh_s && !slow_mode)
    |=> !cpu_hold_o) else $error("hold kept after release");
  index_void_a: assert property (@(posedge clk_i) disable iff (!rstn_i)  // [RQ15]
    (data_acc && !(io_req_i.wr && io_req_i.addr == `IDX_PORT)) |=> !idx_valid)
    else $error("index survived data access");
  version_ro_a: assert property (@(posedge clk_i) disable iff (!rstn_i)  // [RQ17]
    (io_req_i.rd && data_acc && idx_valid && idx == `IDX_CONTROL_ONE) |=> io_rdata_o[7:6] == `CTL_VERSION)
    else $error("version field not read-only");
  refresh_spacing_a: assert property (@(posedge clk_i) disable iff (!rstn_i)  // [RQ19]
    rfsh_tick |=> !rfsh_tick [*8]) else $error("refresh timer too fast");
  slow_duty_a: assert property (@(posedge clk_i) disable iff (!rstn_i)  // [RQ11]
    (slow_mode && phase == 2'h2) |-> !slow_hold) else $error("slow hold in free third");

endmodule : cpu_hold_bus_arbiter
`default_nettype wire

//--- tb/cpu_hold_model.sv
// Behavioural host CPU that answers the hold request
`timescale 1ns/1ps
`default_nettype none
module cpu_hold_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       hold_i,
  input  wire logic [3:0] lag_i,
  output logic            hlda_o
);
  logic [3:0] busy;
  // Drain the current bus cycle before acknowledging; lag sets how slow
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy   <= 4'h0;
      hlda_o <= 1'b0;
    end else if (!hold_i) begin
      busy   <= lag_i;
      hlda_o <= 1'b0;
    end else if (busy != 4'h0) begin
      busy <= busy - 4'h1;
    end else begin
      hlda_o <= 1'b1;
    end
  end
endmodule : cpu_hold_model
`default_nettype wire

//--- tb/cpu_hold_bus_arbiter_tb_top.sv
// Self-checking bench: config access, grants, refresh order, slow mode
`timescale 1ns/1ps
`default_nettype none
`include "hold_arb_cfg.svh"
module cpu_hold_bus_arbiter_tb_top;
  localparam int WIN = 10 * `SLOW_DIV_CYCLES * `SLOW_PERIOD_TICKS;
  logic                      clk_i, rstn_i, dma_master_request, byte_dma_addr_enable_n_n, word_dma_addr_enable_n_n, turbo_n, legacy, mref, hlda, hold, rfsh_n, grant;
  logic [3:0]                lag;
  logic [7:0]                rdata;
  hold_arb_pkg::io_req_t     io_req;
  hold_arb_pkg::cycle_kind_t kind;
  hold_arb_pkg::cycle_kind_t kinds [3];
  int                        mismatches, checks, n, m, k;

  cpu_hold_bus_arbiter cpu_hold_bus_arbiter_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .io_req_i(io_req), .io_rdata_o(rdata), .cpu_hlda_i(hlda),
    .dma_master_request_i(dma_master_request), .byte_dma_addr_enable_n_i(byte_dma_addr_enable_n_n), .word_dma_addr_enable_n_i(word_dma_addr_enable_n_n),
    .local_request_turbo_in_n_i(turbo_n), .cpu_mode_legacy_i(legacy), .master_refresh_req_i(mref),
    .cpu_hold_o(hold), .refresh_cycle_n_o(rfsh_n), .dma_master_grant_o(grant), .cycle_kind_o(kind));

  cpu_hold_model cpu_hold_model_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .hold_i(hold), .lag_i(lag), .hlda_o(hlda));

  // Free-running 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // One I/O request, raised after an edge and dropped at the edge that takes it
  task automatic io(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk_i);
    io_req <= '0;
  endtask : io

  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
    io(1'b1, 1'b0, `IDX_PORT, idx);
    io(1'b1, 1'b0, `DATA_PORT, d);
  endtask : cfg_wr

  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
    io(1'b1, 1'b0, `IDX_PORT, idx);
    io(1'b0, 1'b1, `DATA_PORT, 8'h00);
    @(negedge clk_i);
    check(16'(rdata), 16'(exp));
  endtask : cfg_rd

  task automatic pulse_ref;
    @(posedge clk_i);
    mref <= 1'b1;
    @(posedge clk_i);
    mref <= 1'b0;
  endtask : pulse_ref

  // Bounded wait: 0 grant, 1 refresh strobe, 2 hold reaches lvl
  task automatic wait_until(input int sel, input logic lvl);
    for (n = 0; n < 200; n++) begin
      @(negedge clk_i);
      if ((sel == 0 ? grant : sel == 1 ? rfsh_n : hold) === lvl) break;
    end
    if (n >= 200) begin
      mismatches++;
      $display("BAD at %0t: wait ran out", $time);
      conclude();
    end
  endtask : wait_until

  initial begin
    kinds = '{hold_arb_pkg::CYC_DMA8, hold_arb_pkg::CYC_DMA16, hold_arb_pkg::CYC_MASTER};
    {rstn_i, dma_master_request, mref, legacy, lag} = '0;
    {byte_dma_addr_enable_n_n, word_dma_addr_enable_n_n, turbo_n} = '1;
    io_req = '0;
    mismatches = 0;
    checks = 0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Reset values, read-only version bits, index voided by a data read
    cfg_rd(`IDX_CONTROL_ONE, 8'h02);
    cfg_rd(`IDX_SHADOW_ONE, 8'hE4);
    cfg_wr(`IDX_CONTROL_ONE, 8'hFA);
    cfg_rd(`IDX_CONTROL_ONE, 8'h3A);
    io(1'b0, 1'b1, `DATA_PORT, 8'h00);
    @(negedge clk_i);
    check(16'(rdata), 16'h0000);
    io(1'b1, 1'b0, `DATA_PORT, 8'h10);
    cfg_rd(`IDX_CONTROL_ONE, 8'h3A);
    cfg_wr(`IDX_CONTROL_ONE, 8'h02);
    // Refresh that came first owns the bus first; requester keeps asking
    pulse_ref();
    @(posedge clk_i);
    dma_master_request <= 1'b1;
    wait_until(1, 1'b0);
    check(16'({grant, hold}), 16'h0001);
    wait_until(0, 1'b1);
    check(16'(rfsh_n), 16'h0001);
    @(posedge clk_i);
    dma_master_request <= 1'b0;
    wait_until(2, 1'b0);
    // Each cycle kind, slow and prompt CPU, refresh queued behind the master
    for (k = 0; k < 3; k++) begin
      @(posedge clk_i);
      lag <= 4'(k * 6);
      dma_master_request <= 1'b1;
      byte_dma_addr_enable_n_n <= (k != 0);
      word_dma_addr_enable_n_n <= (k != 1);
      wait_until(0, 1'b1);
      check(16'({hold, hlda}), 16'h0003);
      repeat (6) @(negedge clk_i);
      check(16'(kind), 16'(kinds[k]));
      if (k == 2) pulse_ref();
      @(posedge clk_i);
      dma_master_request <= 1'b0;
      if (k == 2) begin
        wait_until(1, 1'b0);
        check(16'({grant, hold}), 16'h0001);
        for (m = 0; m < 50 && rfsh_n === 1'b0; m++) @(negedge clk_i);
        check(16'(m), 16'(`REFRESH_LEN));
      end
      wait_until(2, 1'b0);
      check(16'({grant, rfsh_n}), 16'h0001);
    end
    // Hidden refresh leaves the CPU running
    cfg_wr(`IDX_SHADOW_ONE, 8'hE0);
    pulse_ref();
    wait_until(1, 1'b0);
    check(16'(hold), 16'h0000);
    // Throttle with turbo control on only in legacy mode with the pin low
    cfg_wr(`IDX_CONTROL_ONE, 8'h12);
    for (k = 0; k < 3; k++) begin
      @(posedge clk_i);
      legacy <= (k != 2);
      turbo_n <= (k == 1);
      repeat (100) @(negedge clk_i);
      m = 0;
      repeat (WIN) begin
        @(negedge clk_i);
        m += int'(hold === 1'b1);
      end
      check(16'(m), (k == 0) ? 16'(WIN * (`SLOW_PERIOD_TICKS - 1) / `SLOW_PERIOD_TICKS) : 16'h0000);
    end
    // Timer refresh recurs at its period; a missing strobe shows up as a wrong count
    for (n = 0; n < 2 * `REFRESH_CYCLES && rfsh_n !== 1'b0; n++) @(negedge clk_i);
    for (m = 0; m < 2 * `REFRESH_CYCLES && rfsh_n === 1'b0; m++) @(negedge clk_i);
    for (m = 0; m < 2 * `REFRESH_CYCLES && rfsh_n !== 1'b0; m++) @(negedge clk_i);
    check(16'(m + `REFRESH_LEN), 16'(`REFRESH_CYCLES));
    conclude();
  end
endmodule : cpu_hold_bus_arbiter_tb_top
`default_nettype wire
